// File: inc/wdt_params.svh
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define WDT_ADDR_CTRL      4'h0
`define WDT_ADDR_CMP       4'h1
`define WDT_ADDR_STAT      4'h2
`define WDT_ADDR_MASK      4'h3
`define WDT_ADDR_CFG       4'h4
`define WDT_ADDR_RSTFLAG   4'h5
`define WDT_CTRL_RESET     8'h4f
`define WDT_CMP_RESET      8'hff
`define WDT_BIT_RSTEN      6
`define WDT_BIT_OVF        5
`define WDT_BIT_CLR        4
`define WDT_BIT_LPSTOP     3
`define WDT_BIT_RESERVED   7
`define WDT_BIT_EV         0
`define WDT_PS_HI          2
`define WDT_CTRL_WMASK     8'h6f
`define WDT_PRE_W          10
`define WDT_PRE_BASE_LOG   3
`define WDT_ZERO8          8'h00
`define WDT_ONE8           8'h01
`define WDT_ZERO_PRE       10'h000
`define WDT_RC_FREQ_HZ     44000
`endif

// File: inc/wdt_pkg.sv
package wdt_pkg;
   typedef logic [7:0] wdt_byte_t;
   typedef logic [2:0] wdt_ps_t;
   typedef enum logic [1:0] {
      WDT_ST_OFF   = 2'b00,
      WDT_ST_RUN   = 2'b01,
      WDT_ST_HOLD  = 2'b10
   } wdt_state_t;
endpackage

// File: inc/wdt_tick_if.sv
interface wdt_tick_if;
   logic             tick;
   logic             sync_clear;
   logic [2:0]       ps;
   logic             run;
   modport src (output tick, input sync_clear, input ps, input run);
   modport dst (input tick, output sync_clear, output ps, output run);
endinterface

// File: design/wdt_prescaler.sv
`include "wdt_params.svh"
module wdt_prescaler
   import wdt_pkg::*;
(
   input  wire logic   clock,
   input  wire logic   rst,
   input  wire logic   rc_clk,
   wdt_tick_if.src     tk
);
   logic                 rc_s1_reg;
   logic                 rc_s2_reg;
   logic                 rc_s3_reg;
   logic [`WDT_PRE_W-1:0] pre_reg;
   logic [`WDT_PRE_W-1:0] pre_next;
   logic [`WDT_PRE_W-1:0] pre_last;
   logic                 rc_rise;
   logic                 pre_wrap;

   assign rc_rise  = rc_s2_reg & ~rc_s3_reg;
   // Terminal count is 2^(ps+3)-1.
   assign pre_last = `WDT_PRE_W'((1 << (32'(tk.ps) + `WDT_PRE_BASE_LOG)) - 1);  // RULE_07
   assign pre_wrap = rc_rise && (pre_reg >= pre_last);
   assign pre_next = (tk.sync_clear || !tk.run) ? `WDT_ZERO_PRE :
                     pre_wrap ? `WDT_ZERO_PRE :
                     rc_rise ? pre_reg + `WDT_PRE_W'(1) : pre_reg;
   assign tk.tick  = pre_wrap && tk.run && !tk.sync_clear;  // RULE_01

   always_ff @(posedge clock) begin
      if (rst) begin
         rc_s1_reg <= 1'b0;
         rc_s2_reg <= 1'b0;
         rc_s3_reg <= 1'b0;
         pre_reg   <= `WDT_ZERO_PRE;
      end else begin
         rc_s1_reg <= rc_clk;
         rc_s2_reg <= rc_s1_reg;
         rc_s3_reg <= rc_s2_reg;
         pre_reg   <= pre_next;
      end
   end
endmodule

// File: design/wdt_timer.sv
// Contract
// RULE_01 - Counter increments on the low-frequency RC clock after prescaling.
// RULE_02 - Reset-enable set: overflow resets system; clear: overflow requests interrupt.
// RULE_03 - Every overflow sets the overflow flag; it holds until software writes zero.
// RULE_04 - Writing one to counter-clear zeroes the counter; the bit reads zero.
// RULE_05 - Low-power stop clear: keep counting in idle and power-down, waking system.
// RULE_06 - Low-power stop set: counter halts during idle or power-down.
// RULE_07 - Prescale codes 000 to 111 divide by 8 through 1024.
// RULE_08 - Counter equal to compare value signals overflow and restarts from zero.
// RULE_09 - Compare value zero disables the watchdog; non-zero starts it.
// RULE_10 - Overflow interval is prescale times compare plus one RC periods.
// RULE_11 - Watchdog-caused reset sets a watchdog reset flag readable by software.
// RULE_12 - Interrupt request asserted while overflow flag and interrupt enable are set.
//
// The placing of the registers and the strobed register port were decided locally.
`include "wdt_params.svh"
module wdt_timer
   import wdt_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        rc_clk,
   input  wire logic        sleep_mode,
   input  wire logic        global_irq_enable,
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [7:0]  rdata,
   output logic             wdt_irq,
   output logic             sys_reset_req,
   output logic             wake_req,
   output logic             irq
);
   wdt_tick_if tk ();

   wdt_byte_t  ctrl_reg;
   wdt_byte_t  ctrl_next;
   wdt_byte_t  cmp_reg;
   wdt_byte_t  cnt_reg;
   wdt_byte_t  cnt_next;
   wdt_byte_t  rdata_reg;
   wdt_byte_t  rdata_next;
   logic       irq_en_reg;
   logic       rstflag_reg;
   logic       rstflag_next;
   logic       stat_reg;
   logic       stat_next;
   logic       mask_reg;
   logic       sleep_s1_reg;
   logic       sleep_s2_reg;
   logic       sys_reset_reg;
   logic       clr_pend_reg;
   wdt_state_t state_reg;
   wdt_state_t state_next;

   wire        wr_ctrl    = wr_en && (addr == `WDT_ADDR_CTRL);
   wire        wr_cmp     = wr_en && (addr == `WDT_ADDR_CMP);
   wire        wr_stat    = wr_en && (addr == `WDT_ADDR_STAT);
   wire        wr_mask    = wr_en && (addr == `WDT_ADDR_MASK);
   wire        wr_cfg     = wr_en && (addr == `WDT_ADDR_CFG);
   wire        wr_rflag   = wr_en && (addr == `WDT_ADDR_RSTFLAG);
   wire        rst_en     = ctrl_reg[`WDT_BIT_RSTEN];
   wire        lp_stop    = ctrl_reg[`WDT_BIT_LPSTOP];
   wire        ovf_flag   = ctrl_reg[`WDT_BIT_OVF];
   wire        clr_req    = wr_ctrl && wdata[`WDT_BIT_CLR];
   wire        enabled    = (cmp_reg != `WDT_ZERO8);
   wire        running    = (state_reg == WDT_ST_RUN);
   wire        overflow   = running && tk.tick && (cnt_reg == cmp_reg);
   wire        irq_line   = ovf_flag && irq_en_reg;

   // Run state: off when compare is zero, hold while sleeping with stop bit set.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         WDT_ST_OFF: begin
            if (enabled) begin
               state_next = WDT_ST_RUN;  // RULE_09
            end
         end
         WDT_ST_RUN: begin
            if (!enabled) begin
               state_next = WDT_ST_OFF;  // RULE_09
            end else if (sleep_s2_reg && lp_stop) begin
               state_next = WDT_ST_HOLD;  // RULE_06
            end
         end
         WDT_ST_HOLD: begin
            if (!enabled) begin
               state_next = WDT_ST_OFF;
            end else if (!(sleep_s2_reg && lp_stop)) begin
               state_next = WDT_ST_RUN;  // RULE_05
            end
         end
         default: begin
            state_next = WDT_ST_OFF;
         end
      endcase
   end

   assign tk.ps         = ctrl_reg[`WDT_PS_HI:0];
   assign tk.run        = running;
   assign tk.sync_clear = clr_req || clr_pend_reg || !enabled;

   wdt_prescaler u_pre (
      .clock  (clock),
      .rst    (rst),
      .rc_clk (rc_clk),
      .tk     (tk)
   );

   // Counter: clear request wins, match wraps to zero, otherwise count ticks.
   always_comb begin
      cnt_next = cnt_reg;
      if (tk.sync_clear) begin
         cnt_next = `WDT_ZERO8;  // RULE_04
      end else if (overflow) begin
         cnt_next = `WDT_ZERO8;  // RULE_08
      end else if (running && tk.tick) begin
         cnt_next = cnt_reg + `WDT_ONE8;  // RULE_01 RULE_10
      end
   end

   // Control register: set of the overflow flag wins over a software clear.
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = (wdata & `WDT_CTRL_WMASK) | (ctrl_reg & ~`WDT_CTRL_WMASK);
         ctrl_next[`WDT_BIT_OVF] = ctrl_reg[`WDT_BIT_OVF] & wdata[`WDT_BIT_OVF];  // RULE_03
      end
      ctrl_next[`WDT_BIT_CLR] = 1'b0;  // RULE_04
      ctrl_next[`WDT_BIT_RESERVED] = 1'b0;
      if (overflow) begin
         ctrl_next[`WDT_BIT_OVF] = 1'b1;  // RULE_03
      end
   end

   // Sticky status for the interrupt output, write one to clear, set wins.
   assign stat_next = overflow | (stat_reg & ~(wr_stat & wdata[`WDT_BIT_EV]));

   // Reset flag survives the watchdog reset itself; software writes one to clear.
   assign rstflag_next = (overflow && rst_en) | (rstflag_reg & ~(wr_rflag & wdata[`WDT_BIT_EV]));  // RULE_11

   always_comb begin
      rdata_next = `WDT_ZERO8;
      if (rd_en) begin
         if (addr == `WDT_ADDR_CTRL) begin
            rdata_next = ctrl_reg;
         end else if (addr == `WDT_ADDR_CMP) begin
            rdata_next = cmp_reg;
         end else if (addr == `WDT_ADDR_STAT) begin
            rdata_next = {7'h00, stat_reg};
         end else if (addr == `WDT_ADDR_MASK) begin
            rdata_next = {7'h00, mask_reg};
         end else if (addr == `WDT_ADDR_CFG) begin
            rdata_next = {7'h00, irq_en_reg};
         end else if (addr == `WDT_ADDR_RSTFLAG) begin
            rdata_next = {7'h00, rstflag_reg};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_reg     <= `WDT_CTRL_RESET;
         cmp_reg      <= `WDT_CMP_RESET;
         cnt_reg      <= `WDT_ZERO8;
         state_reg    <= WDT_ST_OFF;
         clr_pend_reg <= 1'b0;
         sleep_s1_reg <= 1'b0;
         sleep_s2_reg <= 1'b0;
         irq_en_reg   <= 1'b0;
         stat_reg     <= 1'b0;
         mask_reg     <= 1'b0;
         rdata_reg    <= `WDT_ZERO8;
         sys_reset_reg <= 1'b0;
      end else begin
         ctrl_reg     <= ctrl_next;
         cnt_reg      <= cnt_next;
         state_reg    <= state_next;
         clr_pend_reg <= clr_req;
         sleep_s1_reg <= sleep_mode;
         sleep_s2_reg <= sleep_s1_reg;
         stat_reg     <= stat_next;
         rdata_reg    <= rdata_next;
         sys_reset_reg <= overflow && rst_en;  // RULE_02
         if (wr_cmp) begin
            cmp_reg <= wdata;  // RULE_09
         end
         if (wr_mask) begin
            mask_reg <= wdata[`WDT_BIT_EV];
         end
         if (wr_cfg) begin
            irq_en_reg <= wdata[`WDT_BIT_EV];
         end
      end
   end

   // The reset flag is cleared only by its own write, not by rst.
   always_ff @(posedge clock) begin
      rstflag_reg <= rstflag_next;
   end

   assign rdata         = rdata_reg;
   assign sys_reset_req = sys_reset_reg;  // RULE_02
   assign wdt_irq       = irq_line && !rst_en;  // RULE_12 RULE_02
   assign wake_req      = sleep_s2_reg && (sys_reset_reg || (wdt_irq && global_irq_enable));  // RULE_05
   assign irq           = stat_reg && mask_reg;
endmodule

// File: tb/wdt_timer_checker.sv
module wdt_timer_checker (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       rc_clk,
   input wire logic       sleep_mode,
   input wire logic       global_irq_enable,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rdata,
   input wire logic       wdt_irq,
   input wire logic       sys_reset_req,
   input wire logic       wake_req,
   input wire logic       irq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_clr_reads_zero: assert property (rd_en && addr == 4'h0 |=> !rdata[7] && !rdata[4])
      else $error("control bits 7 or 4 read set");
   a_flag_in_ctrl: assert property (rd_en && addr == 4'h0 && wdt_irq |=> rdata[6:5] == 2'b01)
      else $error("flag or reset enable wrong");
   a_irq_enable_rd: assert property (rd_en && addr == 4'h4 && wdt_irq |=> rdata[0])
      else $error("irq without enable");
   a_status_irq: assert property (irq && rd_en && addr inside {4'h2, 4'h3} |=> rdata[0])
      else $error("irq without status and mask");
   a_cmp_readback: assert property ((wr_en && addr == 4'h1) ##1 (rd_en && addr == 4'h1)
      |=> rdata == $past(wdata, 2))
      else $error("compare readback wrong");
   a_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req [*8])
      else $error("reset request too long");
   a_wake_sleep: assert property (!sleep_mode && !$past(sleep_mode) && !$past(sleep_mode, 2)
      && !$past(sleep_mode, 3) |-> !wake_req)
      else $error("wake while awake");
   a_wake_cause: assert property (wake_req && !sys_reset_req |-> wdt_irq && global_irq_enable)
      else $error("wake without cause");
endmodule

// File: tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clock = 0, rst = 1, rc_clk = 0, sleep_mode = 0, global_irq_enable = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata;
   logic       wr_en = 0, rd_en = 0, wdt_irq, sys_reset_req, wake_req, irq;
   int         n_fail = 0, n_compared = 0, c;
   wire  [2:0] ev = {wake_req, sys_reset_req, wdt_irq};
   always #50 clock = ~clock;
   always #370 rc_clk = ~rc_clk;
   wdt_timer dut (.clock(clock), .rst(rst), .rc_clk(rc_clk), .sleep_mode(sleep_mode),
      .global_irq_enable(global_irq_enable), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .wdt_irq(wdt_irq), .sys_reset_req(sys_reset_req), .wake_req(wake_req), .irq(irq));
   function automatic int nrc(input int p, input int cm);
      return (8 << p) * (cm + 1);
   endfunction
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clock);
      wr_en <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic w = 1'b0);
      if (w) begin
         wr_en <= 1'b1;
         wdata <= e;
         addr <= a;
         @(posedge clock);
         wr_en <= 1'b0;
      end
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      @(negedge clock);
      chk(rdata === e, "read data");
      @(posedge clock);
   endtask
   task automatic wt(input int k, input int lim, input bit want);
      c = 0;
      do begin
         @(negedge clock);
         c++;
      end while (ev[k] !== 1'b1 && c < lim);
      chk((c < lim) == want, "event timing");
      if (want && c >= lim) end_of_test();
      @(posedge clock);
   endtask
   initial begin
      void'($urandom(82869));
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      wr(4'h5, 8'h01);
      rd(4'h0, 8'h4f);
      rd(4'h1, 8'hff);
      rd(4'h2, 8'h00);
      rd(4'h9, 8'h00);
      rd(4'h5, 8'h00);
      repeat (4) rd(4'h1, 8'($urandom_range(255, 1)), 1'b1);
      wr(4'h0, 8'hff);
      rd(4'h0, 8'h4f);
      wr(4'h1, 8'h01);
      wr(4'h4, 8'h01);
      for (int p = 0; p < 8; p++) begin
         wr(4'h0, 8'(p));
         wt(0, nrc(p, 1) * 8 + 8000, 1'b1);
         wr(4'h0, 8'(p));
         wt(0, nrc(p, 1) * 8 + 50, 1'b1);
         chk(c >= nrc(p, 1) * 7 - 10, "interval short");
      end
      rd(4'h0, 8'h27);
      chk(irq === 1'b0, "masked irq");
      wr(4'h3, 8'h01);
      rd(4'h2, 8'h01);
      rd(4'h4, 8'h01);
      chk(irq === 1'b1, "irq");
      wr(4'h2, 8'h01);
      chk(irq === 1'b0, "status clear");
      wr(4'h0, 8'h00);
      chk(wdt_irq === 1'b0, "flag clear");
      repeat (8) begin
         wr(4'h0, 8'h30);
         wt(0, 40, 1'b0);
      end
      wr(4'h1, 8'h00);
      wt(0, 400, 1'b0);
      wr(4'h1, 8'h01);
      wr(4'h0, 8'h08);
      sleep_mode <= 1'b1;
      wt(0, 400, 1'b0);
      global_irq_enable <= 1'b1;
      wr(4'h0, 8'h00);
      wt(2, 400, 1'b1);
      rd(4'h0, 8'h20);
      sleep_mode <= 1'b0;
      wr(4'h0, 8'h40);
      wt(1, 400, 1'b1);
      chk(wdt_irq === 1'b0, "irq with reset");
      rd(4'h5, 8'h01);
      end_of_test();
   end
endmodule
bind wdt_timer wdt_timer_checker u_chk (.clock(clock), .rst(rst), .rc_clk(rc_clk), .sleep_mode(sleep_mode),
   .global_irq_enable(global_irq_enable), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
   .rdata(rdata), .wdt_irq(wdt_irq), .sys_reset_req(sys_reset_req), .wake_req(wake_req), .irq(irq));
